// [design/eeprom_pkg.sv]
package eeprom_pkg;
  localparam int          CLK_HZ                 = 25_000_000;
  localparam int          INTERNAL_PROGRAM_TIME_US = 5000;
  localparam int          PROGRAM_CYCLES         = INTERNAL_PROGRAM_TIME_US * (CLK_HZ / 1_000_000);
  localparam int          PAGE_BYTES             = 8;
  localparam int          PAGES                  = 32;
  localparam int          MEM_BYTES              = PAGE_BYTES * PAGES;
  localparam int          ADDR_W                 = 8;
  localparam int          PAGE_LSB_W             = 3;
  localparam logic [3:0]  DEV_TYPE_CODE          = 4'hA;
  localparam logic [2:0]  MODULE_SEL_CODE        = 3'h0;
  localparam logic [7:0]  ADDR_CTR_RESET         = 8'h00;
  localparam logic [7:0]  MEM_RESET_VALUE        = 8'hFF;
  localparam logic [3:0]  BIT_LAST               = 4'h7;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_DEVADDR  = 3'b001,
    ST_DEVACK   = 3'b011,
    ST_WORDADDR = 3'b010,
    ST_WDATA    = 3'b110,
    ST_WACK     = 3'b111,
    ST_RDATA    = 3'b101,
    ST_RACK     = 3'b100
  } bus_state_e;
endpackage : eeprom_pkg

// [design/pin_sync.sv]
module pin_sync
  import eeprom_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic pin_in,
  output logic      pin_sync_out,
  output logic      pin_rise,
  output logic      pin_fall
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
    end
    else
    begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign pin_sync_out = sync_r;
  assign pin_rise     = sync_r & ~prev_r;
  assign pin_fall     = ~sync_r & prev_r;
endmodule : pin_sync

// [design/program_timer.sv]
module program_timer
  import eeprom_pkg::*;
#(
  parameter int CYCLES = PROGRAM_CYCLES
)
(
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic start,
  output logic      busy
);
  logic [$clog2(CYCLES+1)-1:0] count_r;

  // Counts the self-timed programming interval from the stop
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      count_r <= '0;
    else if (start)
      count_r <= ($clog2(CYCLES+1))'(CYCLES);
    else if (count_r != '0)
      count_r <= count_r - 1'b1;
  end

  assign busy = (count_r != '0);
endmodule : program_timer

// [design/two_wire_eeprom_slave.sv]
module two_wire_eeprom_slave
  import eeprom_pkg::*;
#(
  parameter int PROGRAM_CYCLES_P = PROGRAM_CYCLES,
  parameter bit MODULE_VARIANT   = 1'b0
)
(
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic write_protect,
  output logic      busy
);
  logic       scl_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       sda_s;
  logic       sda_rise;
  logic       sda_fall;
  logic       wp_s;
  logic       prog_busy;
  logic       prog_start;

  bus_state_e state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] addr_ctr_r;
  logic       sda_oe_r;
  logic       busy_r;
  logic       ack_drive_r;
  logic       master_ack_r;

  logic [7:0] mem [MEM_BYTES];
  logic [7:0] page_buf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_valid_r;
  logic [ADDR_W-1:0]     page_base_r;
  logic       write_pending_r;
  logic       prog_run_r;
  logic       start_det;
  logic       stop_det;
  logic       addr_match;
  logic [7:0] rx_byte;

  pin_sync scl_sync (
    .sys_clk      (sys_clk),
    .resetn       (resetn),
    .pin_in       (scl_in),
    .pin_sync_out (scl_s),
    .pin_rise     (scl_rise),
    .pin_fall     (scl_fall)
  );

  pin_sync sda_sync (
    .sys_clk      (sys_clk),
    .resetn       (resetn),
    .pin_in       (sda_in),
    .pin_sync_out (sda_s),
    .pin_rise     (sda_rise),
    .pin_fall     (sda_fall)
  );

  pin_sync wp_sync (
    .sys_clk      (sys_clk),
    .resetn       (resetn),
    .pin_in       (write_protect),
    .pin_sync_out (wp_s),
    .pin_rise     (),
    .pin_fall     ()
  );

  program_timer #(
    .CYCLES (PROGRAM_CYCLES_P)
  ) prog_timer (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .start   (prog_start),
    .busy    (prog_busy)
  );

  // Data edges with clock high are framing, not data
  assign start_det = sda_fall & scl_s & ~prog_busy;
  assign stop_det  = sda_rise & scl_s & ~prog_busy;
  assign rx_byte   = {shift_r[6:0], sda_s};

  // Judged on the falling edge after bit eight, when the shift register holds the whole word
  assign addr_match = (shift_r[7:4] == DEV_TYPE_CODE) &&
                      (!MODULE_VARIANT || shift_r[3:1] == MODULE_SEL_CODE);

  // Programming starts only from a stop after written data, unprotected
  assign prog_start = stop_det && write_pending_r && !wp_s;

  // Protocol state machine
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r      <= ST_IDLE;
      bit_cnt_r    <= 4'h0;
      shift_r      <= 8'h00;
      ack_drive_r  <= 1'b0;
      master_ack_r <= 1'b0;
    end
    else if (prog_busy)
    begin
      state_r     <= ST_IDLE;
      ack_drive_r <= 1'b0;
    end
    else if (start_det)
    begin
      state_r     <= ST_DEVADDR;
      bit_cnt_r   <= 4'h0;
      ack_drive_r <= 1'b0;
    end
    else if (stop_det)
    begin
      state_r     <= ST_IDLE;
      ack_drive_r <= 1'b0;
    end
    else if (scl_rise)
    begin
      // Sampling on the rising clock edge
      case (state_r)
        ST_DEVADDR, ST_WORDADDR, ST_WDATA:
        begin
          shift_r   <= rx_byte;
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end
        ST_RACK:
          master_ack_r <= ~sda_s;
        default:
          ;
      endcase
    end
    else if (scl_fall)
    begin
      case (state_r)
        ST_DEVADDR:
          if (bit_cnt_r == 4'h8)
          begin
            if (addr_match)
            begin
              state_r     <= ST_DEVACK;
              ack_drive_r <= 1'b1;
            end
            else
              state_r <= ST_IDLE;
          end
        ST_DEVACK:
        begin
          ack_drive_r <= 1'b0;
          bit_cnt_r   <= 4'h0;
          state_r     <= shift_r[0] ? ST_RDATA : ST_WORDADDR;
        end
        ST_WORDADDR, ST_WDATA:
          if (bit_cnt_r == 4'h8)
          begin
            state_r     <= ST_WACK;
            ack_drive_r <= 1'b1;
          end
        ST_WACK:
        begin
          ack_drive_r <= 1'b0;
          bit_cnt_r   <= 4'h0;
          state_r     <= ST_WDATA;
        end
        ST_RDATA:
          if (bit_cnt_r == BIT_LAST)
          begin
            state_r   <= ST_RACK;
            bit_cnt_r <= 4'h0;
          end
          else
            bit_cnt_r <= bit_cnt_r + 4'h1;
        ST_RACK:
          state_r <= master_ack_r ? ST_RDATA : ST_IDLE;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // Address counter and page collection
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      addr_ctr_r      <= ADDR_CTR_RESET;
      page_valid_r    <= '0;
      page_base_r     <= '0;
      write_pending_r <= 1'b0;
    end
    else if (!prog_busy && start_det)
      write_pending_r <= 1'b0;
    else if (!prog_busy && scl_fall)
    begin
      if (state_r == ST_WORDADDR && bit_cnt_r == 4'h8)
      begin
        addr_ctr_r   <= shift_r;
        page_base_r  <= shift_r;
        page_valid_r <= '0;
      end
      else if (state_r == ST_WDATA && bit_cnt_r == 4'h8)
      begin
        page_valid_r[addr_ctr_r[PAGE_LSB_W-1:0]] <= 1'b1;
        write_pending_r <= 1'b1;
        // Only the in-page bits advance
        addr_ctr_r <= {addr_ctr_r[7:PAGE_LSB_W],
                       addr_ctr_r[PAGE_LSB_W-1:0] + 3'h1};
      end
      else if (state_r == ST_RDATA && bit_cnt_r == BIT_LAST)
        addr_ctr_r <= addr_ctr_r + 8'h01;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!prog_busy && scl_fall && state_r == ST_WDATA && bit_cnt_r == 4'h8)
      page_buf[addr_ctr_r[PAGE_LSB_W-1:0]] <= shift_r;
  end

  // Array commit once the programming interval finishes
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      prog_run_r <= 1'b0;
    else if (prog_start)
      prog_run_r <= 1'b1;
    else if (prog_run_r && !prog_busy)
      prog_run_r <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (prog_run_r && !prog_busy)
    begin
      for (int i = 0; i < PAGE_BYTES; i++)
      begin
        if (page_valid_r[i])
          mem[{page_base_r[7:PAGE_LSB_W], 3'(i)}] <= page_buf[i];
      end
    end
  end

  // Output driver, changes after falling clock edges
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      sda_oe_r <= 1'b0;
    else if (prog_busy || start_det || stop_det)
      sda_oe_r <= 1'b0;
    else if (scl_fall)
    begin
      if (state_r == ST_DEVADDR && bit_cnt_r == 4'h8)
        sda_oe_r <= addr_match;
      else if ((state_r == ST_WORDADDR || state_r == ST_WDATA) && bit_cnt_r == 4'h8)
        sda_oe_r <= 1'b1;
      else if (state_r == ST_DEVACK && shift_r[0])
        sda_oe_r <= ~mem[addr_ctr_r][7];
      else if (state_r == ST_RDATA && bit_cnt_r != BIT_LAST)
        sda_oe_r <= ~mem[addr_ctr_r][3'(BIT_LAST - bit_cnt_r - 4'h1)];
      else if (state_r == ST_RACK && master_ack_r)
        sda_oe_r <= ~mem[addr_ctr_r][7];
      else
        sda_oe_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      busy_r <= 1'b0;
    else
      busy_r <= prog_busy;
  end

  assign sda_out = 1'b0;
  assign sda_oe  = sda_oe_r;
  assign busy    = busy_r;
endmodule : two_wire_eeprom_slave

// [dv/two_wire_eeprom_slave_checker.sv]
module two_wire_eeprom_slave_checker
#(
  parameter int PROGRAM_CYCLES_P = 200
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic write_protect,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 100ps;
  int busy_cnt_r;
  int stop_age_r;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      busy_cnt_r <= 0;
    else
      busy_cnt_r <= busy ? busy_cnt_r + 1 : 0;
  end
  // Cycles since a stop was seen on the pins
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      stop_age_r <= 99;
    else
      stop_age_r <= (scl_in && $rose(sda_in)) ? 0 : (stop_age_r < 99 ? stop_age_r + 1 : 99);
  end
  sequence s_quiet;
    (!sda_oe && !busy) [*3];
  endsequence
  sequence s_hold;
    sda_oe [*6];
  endsequence
  property p_od;
    sda_oe |-> !sda_out;
  endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  property p_steady;
    scl_in && $past(scl_in) && $past(scl_in, 2) |-> $stable(sda_oe);
  endproperty
  a_steady: assert property (p_steady) else $error("data moved with clock high");
  property p_rst;
    $rose(resetn) |-> s_quiet;
  endproperty
  a_rst: assert property (p_rst) else $error("not quiet after reset");
  property p_hold;
    $rose(sda_oe) |-> s_hold;
  endproperty
  a_hold: assert property (p_hold) else $error("low bit too short");
  property p_deaf;
    busy |-> !sda_oe;
  endproperty
  a_deaf: assert property (p_deaf) else $error("answer while programming");
  property p_len;
    $fell(busy) |-> busy_cnt_r == PROGRAM_CYCLES_P;
  endproperty
  a_len: assert property (p_len) else $error("program time wrong");
  property p_from_stop;
    $rose(busy) |-> stop_age_r <= 6;
  endproperty
  a_from_stop: assert property (p_from_stop) else $error("program without stop");
  property p_wp;
    $rose(busy) |-> !write_protect;
  endproperty
  a_wp: assert property (p_wp) else $error("program while protected");
endmodule : two_wire_eeprom_slave_checker
bind two_wire_eeprom_slave two_wire_eeprom_slave_checker #(.PROGRAM_CYCLES_P(PROGRAM_CYCLES_P)) i_chk (
  .sys_clk(sys_clk), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .write_protect(write_protect), .busy(busy));

// [dv/bus_master_model.sv]
module bus_master_model
(
  input  wire logic sys_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic bit_io(input logic b, output logic r);
    cyc(2);
    sda_low = !b;
    cyc(2);
    scl = 1'b1;
    cyc(3);
    r = sda;
    cyc(1);
    scl = 1'b0;
  endtask : bit_io
  task automatic start();
    cyc(2);
    sda_low = 1'b0;
    cyc(4);
    scl = 1'b1;
    cyc(2);
    sda_low = 1'b1;
    cyc(2);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    cyc(2);
    sda_low = 1'b1;
    cyc(4);
    scl = 1'b1;
    cyc(2);
    sda_low = 1'b0;
    cyc(6);
  endtask : stop
  // Clocks with data released until the line reads high while the clock is high
  task automatic recover(output int n);
    n = 0;
    sda_low = 1'b0;
    for (int k = 1; k <= 9 && n == 0; k++)
    begin
      cyc(4);
      scl = 1'b1;
      cyc(3);
      if (sda)
        n = k;
      else
      begin
        cyc(1);
        scl = 1'b0;
      end
    end
  endtask : recover
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : wr_byte
  task automatic rd_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(!more, r);
  endtask : rd_byte
endmodule : bus_master_model

// [dv/two_wire_eeprom_slave_test.sv]
module two_wire_eeprom_slave_test
  import eeprom_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int         PROG  = 200;
  localparam logic [7:0] DEV_W = {DEV_TYPE_CODE, 4'h0};
  localparam logic [7:0] DEV_R = {DEV_TYPE_CODE, 4'h1};
  logic sys_clk;
  logic resetn;
  logic write_protect;
  logic scl;
  logic sda_low;
  logic sda;
  logic sda_oe;
  logic sda_out;
  logic busy;
  int   error_cnt = 0;
  int   n_checks = 0;
  int   cycles = 0;
  // Pull-up on the shared data line
  assign sda = !((sda_oe && !sda_out) || sda_low);
  two_wire_eeprom_slave #(.PROGRAM_CYCLES_P(PROG), .MODULE_VARIANT(1'b0)) i_dut (.sys_clk(sys_clk),
    .resetn(resetn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .write_protect(write_protect), .busy(busy));
  bus_master_model i_master (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = !sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 12000)
    begin
      error_cnt++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte
  // Array contents expected after the two page writes
  function automatic logic [7:0] exp_val(input logic [7:0] a);
    if (a >= 8'hFA)
      return 8'h50 + (a - 8'hF8);
    if (a >= 8'hF8)
      return 8'h58 + (a - 8'hF8);
    return 8'h20 + a;
  endfunction : exp_val
  task automatic send(input logic [7:0] d, input logic exp_ack);
    logic a;
    i_master.wr_byte(d, a);
    chk_bit(a, exp_ack);
  endtask : send
  task automatic set_addr(input logic [7:0] wa);
    i_master.start();
    send(DEV_W, 1'b1);
    send(wa, 1'b1);
  endtask : set_addr
  task automatic end_write(input logic exp_busy);
    i_master.stop();
    chk_bit(busy, exp_busy);
  endtask : end_write
  task automatic wait_idle();
    for (int k = 0; k < 2 * PROG && busy === 1'b1; k++)
      @(posedge sys_clk);
    #1;
    chk_bit(busy, 1'b0);
  endtask : wait_idle
  task automatic read_seq(input logic [7:0] a, input int n);
    logic [7:0] d;
    i_master.start();
    send(DEV_R, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      i_master.rd_byte(i < n - 1, d);
      chk_byte(d, exp_val(a + i[7:0]));
    end
    i_master.stop();
  endtask : read_seq
  task automatic t_addr_match();
    logic [7:0] dev [6] = '{8'hAE, 8'hA6, 8'hA2, 8'h20, 8'hB0, 8'hE0};
    for (int i = 0; i < 6; i++)
    begin
      i_master.start();
      send(dev[i], i < 3);
      i_master.stop();
    end
    chk_bit(busy, 1'b0);
    $display("address match done");
  endtask : t_addr_match
  task automatic t_page_wrap();
    set_addr(8'h00);
    for (int i = 0; i < 8; i++)
      send(8'h20 + i[7:0], 1'b1);
    end_write(1'b1);
    wait_idle();
    set_addr(8'hF8);
    for (int i = 0; i < 10; i++)
      send(8'h50 + i[7:0], 1'b1);
    end_write(1'b1);
    i_master.start();
    send(DEV_W, 1'b0);
    i_master.stop();
    wait_idle();
    set_addr(8'hF8);
    read_seq(8'hF8, 10);
    read_seq(8'h02, 1);
    $display("page write and reads done");
  endtask : t_page_wrap
  task automatic t_write_protect();
    write_protect = 1'b1;
    set_addr(8'h00);
    send(8'h99, 1'b1);
    end_write(1'b0);
    write_protect = 1'b0;
    set_addr(8'h00);
    read_seq(8'h00, 1);
    $display("write protect done");
  endtask : t_write_protect
  task automatic t_recover();
    logic [7:0] d;
    logic       r;
    int         n;
    i_master.start();
    send(DEV_R, 1'b1);
    for (int i = 0; i < 3; i++)
      i_master.bit_io(1'b1, r);
    // Byte 0x21 is being sent; its first high bit after the cut is the fifth
    i_master.recover(n);
    chk_byte(n[7:0], 8'h05);
    i_master.start();
    send(DEV_R, 1'b1);
    i_master.rd_byte(1'b0, d);
    chk_byte(d, 8'h21);
    i_master.stop();
    resetn = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    repeat (4) @(posedge sys_clk);
    read_seq(8'h00, 1);
    $display("recovery and reset done");
  endtask : t_recover
  initial
  begin
    resetn = 1'b0;
    write_protect = 1'b0;
    repeat (20) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    repeat (4) @(posedge sys_clk);
    t_addr_match();
    t_page_wrap();
    t_write_protect();
    t_recover();
    final_report();
  end
endmodule : two_wire_eeprom_slave_test
